// ---- logic/rxc_ctrl.sv ----
// Role, loop-through, input select and luma ancillary flag control
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "rxc_regs.svh"

module rxc_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire rxc_pkg::rxc_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire rxc_pkg::rxc_word_t pwdata,
  output rxc_pkg::rxc_word_t prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous control pins
  input wire logic role_pin,
  input wire logic input_port_select,
  input wire logic carrier_detect_one,
  input wire logic carrier_detect_two,
  input wire logic bus_width_select,
  // Two-way mode pins
  input wire logic asi_mode_pin_in,
  output logic asi_mode_pin_out,
  output logic asi_mode_pin_oe_n,
  input wire logic rate_select_in,
  output logic rate_select_out,
  output logic rate_select_oe_n,
  input wire logic loop_reclock_select_in,
  output logic loop_reclock_select_out,
  output logic loop_reclock_select_oe_n,
  input wire logic video_processing_select_in,
  output logic video_processing_select_out,
  output logic video_processing_select_oe_n,
  // Datapath detector status
  input wire rxc_pkg::rxc_kind_e det_kind,
  input wire logic det_locked,
  input wire logic pix_strobe,
  input wire logic anc_luma_det,
  input wire logic anc_chroma_det,
  // Datapath steering
  output logic serial_in_one_sel,
  output logic carrier_detect,
  output logic loop_reclocked,
  output logic cfg_rate_sd,
  output logic cfg_asi,
  output logic cfg_video_proc,
  output logic cfg_pass_through,
  // Status
  output logic auto_mode,
  output logic locked,
  output logic luma_anc_flag,
  output logic irq
);
  import rxc_pkg::*;

  // Synchronised pins
  logic [8:0] pin_async;
  logic [8:0] pin_sync;
  logic s_role, s_port_one, s_cd_one, s_cd_two, s_width20, s_asi, s_rate_sd, s_reclock, s_proc;

  assign pin_async = {video_processing_select_in, loop_reclock_select_in, rate_select_in,
                      asi_mode_pin_in, bus_width_select, carrier_detect_two,
                      carrier_detect_one, input_port_select, role_pin};

  rxc_sync2 #(.WIDTH(9)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_async),
    .sync_out(pin_sync)
  );

  assign s_role = pin_sync[0];
  assign s_port_one = pin_sync[1];
  assign s_cd_one = pin_sync[2];
  assign s_cd_two = pin_sync[3];
  assign s_width20 = pin_sync[4];
  assign s_asi = pin_sync[5];
  assign s_rate_sd = pin_sync[6];
  assign s_reclock = pin_sync[7];
  assign s_proc = pin_sync[8];

  // Detector decoding
  function automatic logic kind_is_video(input rxc_kind_e k);
    return (k == RXC_KIND_SD) || (k == RXC_KIND_HD);
  endfunction

  function automatic logic kind_is_sd_rate(input rxc_kind_e k);
    return (k == RXC_KIND_SD) || (k == RXC_KIND_ASI);
  endfunction

  // Compliant lock
  logic nxt_locked;
  assign nxt_locked = det_locked && (det_kind != RXC_KIND_NONE);

  // Next configuration
  logic nxt_rate_sd, nxt_asi, nxt_proc, nxt_reclock, nxt_pass;

  always_comb begin
    if (s_role) begin
      nxt_rate_sd = kind_is_sd_rate(det_kind);
      nxt_asi = nxt_locked && (det_kind == RXC_KIND_ASI);
      nxt_proc = nxt_locked && kind_is_video(det_kind);
      nxt_reclock = nxt_locked;
      nxt_pass = 1'b0;
    end else begin
      nxt_rate_sd = s_rate_sd;
      nxt_asi = s_asi && s_rate_sd && !s_proc;
      nxt_proc = s_proc;
      nxt_reclock = s_reclock;
      nxt_pass = !s_asi && !s_proc;
    end
  end

  // Mode pin drive
  logic auto_mode_ff, asi_out_ff, rate_out_ff, rc_out_ff, proc_out_ff, pins_oe_n_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_mode_ff <= 1'b0;
      pins_oe_n_ff <= 1'b1;
      asi_out_ff <= 1'b0;
      rate_out_ff <= 1'b0;
      rc_out_ff <= 1'b0;
      proc_out_ff <= 1'b0;
    end else begin
      auto_mode_ff <= s_role;
      pins_oe_n_ff <= !s_role;
      asi_out_ff <= nxt_asi;
      rate_out_ff <= nxt_rate_sd;
      rc_out_ff <= nxt_reclock;
      proc_out_ff <= nxt_proc;
    end
  end

  assign auto_mode = auto_mode_ff;
  assign asi_mode_pin_out = asi_out_ff;
  assign rate_select_out = rate_out_ff;
  assign loop_reclock_select_out = rc_out_ff;
  assign video_processing_select_out = proc_out_ff;
  assign asi_mode_pin_oe_n = pins_oe_n_ff;
  assign rate_select_oe_n = pins_oe_n_ff;
  assign loop_reclock_select_oe_n = pins_oe_n_ff;
  assign video_processing_select_oe_n = pins_oe_n_ff;

  // Datapath configuration
  logic locked_ff, rate_sd_ff, asi_ff, proc_ff, pass_ff, reclock_ff, port_one_ff, carrier_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_ff <= 1'b0;
      rate_sd_ff <= 1'b0;
      asi_ff <= 1'b0;
      proc_ff <= 1'b0;
      pass_ff <= 1'b0;
      reclock_ff <= 1'b0;
    end else begin
      locked_ff <= nxt_locked;
      rate_sd_ff <= nxt_rate_sd;
      asi_ff <= nxt_asi;
      proc_ff <= nxt_proc;
      pass_ff <= nxt_pass;
      reclock_ff <= nxt_reclock;
    end
  end

  // Input port and carrier select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_one_ff <= 1'b0;
      carrier_ff <= 1'b0;
    end else begin
      port_one_ff <= s_port_one;
      carrier_ff <= s_port_one ? s_cd_one : s_cd_two;
    end
  end

  assign locked = locked_ff;
  assign cfg_rate_sd = rate_sd_ff;
  assign cfg_asi = asi_ff;
  assign cfg_video_proc = proc_ff;
  assign cfg_pass_through = pass_ff;
  assign loop_reclocked = reclock_ff;
  assign serial_in_one_sel = port_one_ff;
  assign carrier_detect = carrier_ff;

  // Luma ancillary flag
  logic anc_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      anc_ff <= 1'b0;
    end else if (pix_strobe) begin
      if (s_width20) begin
        anc_ff <= anc_luma_det;
      end else begin
        anc_ff <= anc_luma_det || anc_chroma_det;
      end
    end
  end

  assign luma_anc_flag = anc_ff;

  // Interrupt events
  logic [`RXC_EV_NUM-1:0] events, int_status_ff, int_enable_ff, int_clear;
  logic irq_ff;

  assign events[`RXC_EV_LOCK_GAIN] = nxt_locked && !locked_ff;
  assign events[`RXC_EV_LOCK_LOSS] = !nxt_locked && locked_ff;
  assign events[`RXC_EV_ROLE] = s_role != auto_mode_ff;
  assign events[`RXC_EV_CARRIER] = (s_port_one ? s_cd_one : s_cd_two) != carrier_ff;
  assign events[`RXC_EV_RATE] = nxt_rate_sd != rate_sd_ff;

  // APB access decode
  logic acc, wr_acc, pready_ff, pslverr_ff;
  rxc_word_t prdata_ff;

  assign acc = psel && penable && !pready_ff;
  assign wr_acc = psel && penable && pready_ff && pwrite && !pslverr_ff;

  function automatic logic addr_mapped(input rxc_addr_t a);
    return (a == `RXC_STATUS_OFS) || (a == `RXC_INT_STATUS_OFS) ||
           (a == `RXC_INT_ENABLE_OFS) || (a == `RXC_INT_CLEAR_OFS);
  endfunction

  assign int_clear = (wr_acc && paddr == `RXC_INT_CLEAR_OFS) ?
                     pwdata[`RXC_EV_NUM-1:0] : '0;

  // Sticky status, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < `RXC_EV_NUM; gi++) begin : g_ev
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          int_status_ff[gi] <= 1'b0;
        end else if (events[gi]) begin
          int_status_ff[gi] <= 1'b1;
        end else if (int_clear[gi]) begin
          int_status_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable_ff <= `RXC_INT_ENABLE_RST;
    end else if (wr_acc && paddr == `RXC_INT_ENABLE_OFS) begin
      int_enable_ff <= pwdata[`RXC_EV_NUM-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_status_ff & int_enable_ff);
    end
  end

  assign irq = irq_ff;

  // Read data
  rxc_word_t rd_word;

  always_comb begin
    rd_word = '0;
    unique case (paddr)
      `RXC_STATUS_OFS: begin
        rd_word[`RXC_ST_AUTO] = auto_mode_ff;
        rd_word[`RXC_ST_LOCKED] = locked_ff;
        rd_word[`RXC_ST_RATE_SD] = rate_sd_ff;
        rd_word[`RXC_ST_ASI] = asi_ff;
        rd_word[`RXC_ST_RECLOCK] = reclock_ff;
        rd_word[`RXC_ST_PROC] = proc_ff;
        rd_word[`RXC_ST_PASS] = pass_ff;
        rd_word[`RXC_ST_PORT_ONE] = port_one_ff;
        rd_word[`RXC_ST_CARRIER] = carrier_ff;
        rd_word[`RXC_ST_WIDTH] = s_width20;
      end
      `RXC_INT_STATUS_OFS: rd_word[`RXC_EV_NUM-1:0] = int_status_ff;
      `RXC_INT_ENABLE_OFS: rd_word[`RXC_EV_NUM-1:0] = int_enable_ff;
      default: rd_word = '0;
    endcase
  end

  // One wait state answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && !addr_mapped(paddr);
      if (acc && !pwrite) begin
        prdata_ff <= rd_word;
      end
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence role_settled;
    $stable(s_role) [*2];
  endsequence

  chk_auto_drives_pins: assert property (role_settled ##0 s_role |-> !asi_mode_pin_oe_n)
    else $error("Auto mode pins not driven");
  chk_manual_releases_pins: assert property (role_settled ##0 !s_role |-> asi_mode_pin_oe_n)
    else $error("Manual mode pins still driven");
  chk_auto_reclock_lock: assert property (auto_mode && loop_reclocked |-> $past(nxt_locked))
    else $error("Reclocked loop without lock");
  chk_auto_buffered: assert property (s_role && !nxt_locked |=> !loop_reclocked)
    else $error("Loop not buffered when unlocked");
  chk_manual_reclock: assert property (!s_role |=> loop_reclocked == $past(s_reclock))
    else $error("Manual loop select not followed");
  chk_port_select: assert property (serial_in_one_sel == $past(s_port_one))
    else $error("Input port select mismatch");
  chk_carrier_pick: assert property (
      ##1 carrier_detect == ($past(s_port_one) ? $past(s_cd_one) : $past(s_cd_two)))
    else $error("Carrier source mismatch");
  chk_auto_rate: assert property (
      s_role && det_kind == RXC_KIND_HD |=> !rate_select_out && !cfg_rate_sd)
    else $error("HD rate not shown low");
  chk_lock_status: assert property (det_locked && det_kind != RXC_KIND_NONE |=> locked)
    else $error("Lock status missing");
  chk_anc_width20: assert property (
      pix_strobe && s_width20 && !anc_luma_det |=> !luma_anc_flag)
    else $error("Flag set without luma ancillary");
  chk_anc_muxed: assert property (
      pix_strobe && !s_width20 && anc_chroma_det |=> luma_anc_flag)
    else $error("Muxed ancillary not flagged");
  chk_anc_hold: assert property (!pix_strobe |=> $stable(luma_anc_flag))
    else $error("Flag moved between pixel words");
  chk_irq_level: assert property (|(int_status_ff & int_enable_ff) |=> irq)
    else $error("Interrupt not raised");
endmodule

// ---- logic/rxc_pkg.sv ----
// Types shared by the receiver control block
package rxc_pkg;
  typedef enum logic [1:0] {
    RXC_KIND_NONE,
    RXC_KIND_SD,
    RXC_KIND_HD,
    RXC_KIND_ASI
  } rxc_kind_e;
  typedef logic [31:0] rxc_word_t;
  typedef logic [7:0] rxc_addr_t;
endpackage

// ---- logic/rxc_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef RXC_REGS_SVH
`define RXC_REGS_SVH

// Register byte offsets
`define RXC_STATUS_OFS 8'h00
`define RXC_INT_STATUS_OFS 8'h04
`define RXC_INT_ENABLE_OFS 8'h08
`define RXC_INT_CLEAR_OFS 8'h0C

// Live status fields
`define RXC_ST_AUTO 0
`define RXC_ST_LOCKED 1
`define RXC_ST_RATE_SD 2
`define RXC_ST_ASI 3
`define RXC_ST_RECLOCK 4
`define RXC_ST_PROC 5
`define RXC_ST_PASS 6
`define RXC_ST_PORT_ONE 7
`define RXC_ST_CARRIER 8
`define RXC_ST_WIDTH 9

// Interrupt event fields
`define RXC_EV_LOCK_GAIN 0
`define RXC_EV_LOCK_LOSS 1
`define RXC_EV_ROLE 2
`define RXC_EV_CARRIER 3
`define RXC_EV_RATE 4
`define RXC_EV_NUM 5

// Reset values
`define RXC_INT_ENABLE_RST 5'h00
`define RXC_SYNC_RST 9'h000

// Synchroniser depth in pclk cycles
`define RXC_SYNC_STAGES 2

`endif

// ---- logic/rxc_sync2.sv ----
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`include "rxc_regs.svh"
module rxc_sync2 #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// ---- tb/rx_role_loop_and_anc_flags_tb.sv ----
// Self-checking bench for the receiver control block
`timescale 1ns/100ps
module rx_role_loop_and_anc_flags_tb;
  import rxc_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  rxc_addr_t paddr = 8'h00;
  rxc_word_t pwdata = 32'h0, prdata, rd;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
  logic role = 1'h0, role_pin, input_port_select = 1'h0, bus_width_select = 1'h0;
  logic carrier_detect_one = 1'h0, carrier_detect_two = 1'h0;
  logic [3:0] want = 4'h0, pin_lvl;
  logic asi_mode_pin_out, asi_mode_pin_oe_n, rate_select_out, rate_select_oe_n;
  logic loop_reclock_select_out, loop_reclock_select_oe_n;
  logic video_processing_select_out, video_processing_select_oe_n;
  rxc_kind_e det_kind = RXC_KIND_NONE;
  logic det_locked = 1'h0, pix_strobe = 1'h0, anc_luma_det = 1'h0, anc_chroma_det = 1'h0;
  logic serial_in_one_sel, carrier_detect, loop_reclocked, cfg_rate_sd, cfg_asi;
  logic cfg_video_proc, cfg_pass_through, auto_mode, locked, luma_anc_flag, irq;
  int num_errors = 0;
  int compares = 0;
  wire [3:0] oe_n = {video_processing_select_oe_n, loop_reclock_select_oe_n,
    rate_select_oe_n, asi_mode_pin_oe_n};
  wire [3:0] dev_out = {video_processing_select_out, loop_reclock_select_out,
    rate_select_out, asi_mode_pin_out};
  always #2.5 pclk = ~pclk;
  rxc_app_model app_u (
    .pclk, .role, .want, .dev_out, .dev_oe_n(oe_n), .role_pin, .pin(pin_lvl)
  );
  rxc_ctrl dut_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .role_pin, .input_port_select, .carrier_detect_one, .carrier_detect_two,
    .bus_width_select, .asi_mode_pin_in(pin_lvl[0]), .asi_mode_pin_out, .asi_mode_pin_oe_n,
    .rate_select_in(pin_lvl[1]), .rate_select_out, .rate_select_oe_n,
    .loop_reclock_select_in(pin_lvl[2]), .loop_reclock_select_out, .loop_reclock_select_oe_n,
    .video_processing_select_in(pin_lvl[3]), .video_processing_select_out,
    .video_processing_select_oe_n, .det_kind, .det_locked, .pix_strobe, .anc_luma_det,
    .anc_chroma_det, .serial_in_one_sel, .carrier_detect, .loop_reclocked, .cfg_rate_sd,
    .cfg_asi, .cfg_video_proc, .cfg_pass_through, .auto_mode, .locked, .luma_anc_flag, .irq
  );
  task automatic tally_and_finish;
    $display("Compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input rxc_addr_t a, input rxc_word_t d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      num_errors++;
      tally_and_finish;
    end
  endtask
  task automatic pix(input logic l, input logic c);
    anc_luma_det <= l;
    anc_chroma_det <= c;
    pix_strobe <= 1'h1;
    step(1);
    pix_strobe <= 1'h0;
    step(1);
  endtask
  task automatic t_reset;
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    check(err, 1'h1);
    check(rd, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_manual;
    want <= 4'h4;
    step(4);
    check(oe_n, 4'hF);
    check(loop_reclocked, 1'h1);
    check(cfg_pass_through, 1'h1);
    want <= 4'h3;
    step(4);
    check(loop_reclocked, 1'h0);
    check({cfg_asi, cfg_rate_sd, auto_mode}, 3'h6);
    $display("manual test done");
  endtask
  task automatic t_auto;
    role <= 1'h1;
    det_kind <= RXC_KIND_HD;
    det_locked <= 1'h1;
    step(4);
    check({oe_n, auto_mode}, 5'h01);
    check({loop_reclocked, loop_reclock_select_out, locked}, 3'h7);
    check({rate_select_out, video_processing_select_out, cfg_video_proc}, 3'h3);
    apb(1'h0, 8'h00, 32'h0);
    check(rd, 32'h33);
    det_kind <= RXC_KIND_ASI;
    step(2);
    check({rate_select_out, asi_mode_pin_out}, 2'h3);
    det_locked <= 1'h0;
    step(2);
    check({loop_reclocked, loop_reclock_select_out, locked}, 3'h0);
    det_locked <= 1'h1;
    det_kind <= RXC_KIND_NONE;
    step(2);
    check({loop_reclocked, locked}, 2'h0);
    $display("auto test done");
  endtask
  task automatic t_select;
    input_port_select <= 1'h1;
    carrier_detect_one <= 1'h1;
    step(4);
    check({serial_in_one_sel, carrier_detect}, 2'h3);
    input_port_select <= 1'h0;
    step(4);
    check({serial_in_one_sel, carrier_detect}, 2'h0);
    carrier_detect_two <= 1'h1;
    step(4);
    check(carrier_detect, 1'h1);
    $display("select test done");
  endtask
  task automatic t_anc;
    bus_width_select <= 1'h1;
    det_kind <= RXC_KIND_SD;
    step(4);
    check(rate_select_out, 1'h1);
    pix(1'h0, 1'h1);
    check(luma_anc_flag, 1'h0);
    det_kind <= RXC_KIND_HD;
    pix(1'h1, 1'h0);
    check(luma_anc_flag, 1'h1);
    anc_luma_det <= 1'h0;
    step(2);
    check(luma_anc_flag, 1'h1);
    bus_width_select <= 1'h0;
    step(4);
    pix(1'h0, 1'h0);
    check(luma_anc_flag, 1'h0);
    pix(1'h0, 1'h1);
    check(luma_anc_flag, 1'h1);
    $display("anc test done");
  endtask
  task automatic t_irq;
    apb(1'h1, 8'h0C, 32'h1F);
    apb(1'h1, 8'h08, 32'h4);
    role <= 1'h0;
    step(6);
    check(irq, 1'h1);
    apb(1'h0, 8'h04, 32'h0);
    check(rd & 32'h4, 32'h4);
    apb(1'h1, 8'h0C, 32'h4);
    step(2);
    check(irq, 1'h0);
    apb(1'h1, 8'h08, 32'h0);
    role <= 1'h1;
    step(6);
    check(irq, 1'h0);
    apb(1'h0, 8'h04, 32'h0);
    check(rd & 32'h4, 32'h4);
    $display("irq test done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    check(oe_n, 4'hF);
    presetn <= 1'h1;
    t_reset;
    t_manual;
    t_auto;
    t_select;
    t_anc;
    t_irq;
    tally_and_finish;
  end
endmodule

// ---- tb/rxc_app_model.sv ----
// Application logic on the far side of the two-way mode pins
`timescale 1ns/100ps
module rxc_app_model (
  // Clock
  input wire logic pclk,
  // Wanted levels
  input wire logic role,
  input wire logic [3:0] want,
  // Device side
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe_n,
  // Pins
  output logic role_pin,
  output logic [3:0] pin
);
  logic [3:0] last_ff;
  assign role_pin = role;
  always_ff @(posedge pclk) begin
    last_ff <= pin;
  end
  // Released lines in manual role follow want; in auto role rate pulls up, others show no stale level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!dev_oe_n[i]) begin
        pin[i] = dev_out[i];
      end else if (!role) begin
        pin[i] = want[i];
      end else begin
        pin[i] = (i == 1) ? 1'h1 : !last_ff[i];
      end
    end
  end
endmodule
